// file: src/dio_defs.svh
// Constants for the digital I/O word port: register offsets, reset values, vector codes.
// Assumes a 16-bit processor bus with a byte address and two byte enables.
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets (even word addresses, low byte = port 1)
// ----------------------------------------------------------------
`define DIO_OFS_IN   5'h00
`define DIO_OFS_OUT  5'h02
`define DIO_OFS_DIR  5'h04
`define DIO_OFS_REN  5'h06
`define DIO_OFS_DS   5'h08
`define DIO_OFS_SEL  5'h0A
`define DIO_OFS_PORT1_VECTOR_REG 5'h0E
`define DIO_OFS_IES  5'h18
`define DIO_OFS_IE   5'h1A
`define DIO_OFS_IFG  5'h1C
`define DIO_OFS_PORT2_VECTOR_REG 5'h1E

// ----------------------------------------------------------------
// Reset values and vector encoding
// ----------------------------------------------------------------
`define DIO_RST_WORD  16'h0000
`define DIO_VEC_NONE  8'h00
`define DIO_VEC_BASE  8'h02
`define DIO_SYNC_LAT  2

`endif

// file: src/dio_pkg.sv
// Types shared by the digital I/O word port.
// Assumes dio_defs.svh supplies all numeric constants.
package dio_pkg;
    typedef logic [15:0] dio_word_t;

    // Pad control bundle handed to the pad ring
    typedef struct packed {
        dio_word_t drive;
        dio_word_t drive_en;
        dio_word_t pull_en;
        dio_word_t pull_up;
        dio_word_t drive_full;
    } dio_pad_s;
endpackage

// file: src/dio_port.sv
// Digital I/O word port: two byte ports with edge flags and prioritised vectors.
// Assumes one 250 MHz clock, pins asynchronous, pad ring resolves the pin level.
`include "dio_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// Function
// - Input register returns synchronised pin level, read-only
// - Output pin drives output register bit
// - Output bit chooses pullup or pulldown
// - Direction bit sets pin output enable always
// - Pull enable active only for input pins
// - Drive strength bit, reduced drive after reset
// - Function select routes pin, keeps direction
// - Selected peripheral pins never set flags
// - Peripheral input follows pin, holds when deselected
// - Flags prioritised, bit zero highest
// - Vector shows highest pending enabled flag
// - Vector zero idle, else two plus twice
// - Chosen edge sets the pin flag
// - Edge select zero rising, one falling
// - Request needs flag, enable and global enable
// - Enable bit one allows flag interrupt
// - Software writing one sets a flag
// - Edges set flags, levels never; none lost
// - Pin changes from port writes may flag
// - Edge select change flags matching level
// - Vector low byte access clears winner
// - Remaining flags raise request again immediately
// - Port two has its own vector
// - Word write both bytes, byte write one
// - Word read sixteen bits, byte read half
// - Missing pins read zero, ignore writes
module dio_port #(
    parameter int P1_PINS = 8,
    parameter int P2_PINS = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Processor bus
    input wire logic [4:0] bus_addr_in,
    input wire logic bus_rd_in,
    input wire logic bus_wr_in,
    input wire logic [1:0] bus_be_in,
    input wire logic [15:0] bus_wdata_in,
    output logic [15:0] bus_rdata_out,
    output logic bus_rvalid_out,
    // Pins and pad control
    input wire logic [15:0] pin_in,
    output dio_pkg::dio_pad_s pad_out,
    // Peripheral side
    input wire logic [15:0] periph_drive_in,
    output logic [15:0] periph_in_out,
    // Interrupt request
    input wire logic global_irq_enable_in,
    output logic irq_p1_out,
    output logic irq_p2_out
);
    import dio_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (P1_PINS < 1 || P1_PINS > 8 || P2_PINS < 1 || P2_PINS > 8) begin : g_bad_width
        $error("dio_port: pin counts must be 1 to 8");
    end

    // Implemented-pin mask; missing pins read zero and ignore writes
    localparam logic [15:0] PIN_MASK = {8'(({8{1'b1}} << P2_PINS) ^ {8{1'b1}}),
                                        8'(({8{1'b1}} << P1_PINS) ^ {8{1'b1}})};

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte-lane merge of a bus write
    function automatic dio_word_t merge(input dio_word_t old, input dio_word_t wd, input logic [1:0] be);
        dio_word_t r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r & PIN_MASK;
    endfunction

    // One-hot of the lowest set bit; bit 0 wins
    function automatic logic [7:0] lowest(input logic [7:0] v);
        return v & (~v + 8'h01);
    endfunction

    // Vector code: zero when idle, else 2 + 2 * index
    function automatic logic [7:0] vec_code(input logic [7:0] v);
        logic [7:0] c;
        c = `DIO_VEC_NONE;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                c = `DIO_VEC_BASE + 8'(2 * i);
            end
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dio_word_t sync1_reg, sync2_reg, prev_reg;
    dio_word_t out_reg, out_next, dir_reg, dir_next, ren_reg, ren_next;
    dio_word_t ds_reg, ds_next, sel_reg, sel_next;
    dio_word_t ies_reg, ies_next, ie_reg, ie_next, ifg_reg, ifg_next;
    dio_word_t periph_reg, periph_next;
    dio_pad_s pad_reg, pad_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic irq1_reg, irq1_next, irq2_reg, irq2_next;

    // Combinational helpers
    dio_word_t pend, edge_hit, ies_hit, vec_clr, hw_set;
    logic [7:0] vec1, vec2;
    logic acc1, acc2;

    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    // First stage feeds only the second; edges compare stage two with its past
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync1_reg <= `DIO_RST_WORD;
            sync2_reg <= `DIO_RST_WORD;
            prev_reg <= `DIO_RST_WORD;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sources and vectors
    // ----------------------------------------------------------------
    always_comb begin
        pend = ifg_reg & ie_reg;
        vec1 = vec_code(pend[7:0]);
        vec2 = vec_code(pend[15:8]);
        acc1 = (bus_rd_in || bus_wr_in) && bus_addr_in == `DIO_OFS_PORT1_VECTOR_REG && bus_be_in[0];
        acc2 = (bus_rd_in || bus_wr_in) && bus_addr_in == `DIO_OFS_PORT2_VECTOR_REG && bus_be_in[0];
        vec_clr = {acc2 ? lowest(pend[15:8]) : 8'h00, acc1 ? lowest(pend[7:0]) : 8'h00};
        // Edge per pin as chosen by edge select; level alone never flags
        edge_hit = (~ies_reg & sync2_reg & ~prev_reg) | (ies_reg & ~sync2_reg & prev_reg);
        ies_next = (bus_wr_in && bus_addr_in == `DIO_OFS_IES) ? merge(ies_reg, bus_wdata_in, bus_be_in) : ies_reg;
        // Edge select change with pin already at the new edge's end level
        ies_hit = (ies_next & ~ies_reg & ~sync2_reg) | (~ies_next & ies_reg & sync2_reg);
        hw_set = (edge_hit | ies_hit) & ~sel_reg & PIN_MASK;
    end

    // ----------------------------------------------------------------
    // Register file next state
    // ----------------------------------------------------------------
    // Hardware set wins over vector clear and software clear
    always_comb begin
        out_next = out_reg;
        dir_next = dir_reg;
        ren_next = ren_reg;
        ds_next = ds_reg;
        sel_next = sel_reg;
        ie_next = ie_reg;
        ifg_next = ifg_reg;
        if (bus_wr_in) begin
            unique case (bus_addr_in)
                `DIO_OFS_OUT: out_next = merge(out_reg, bus_wdata_in, bus_be_in);
                `DIO_OFS_DIR: dir_next = merge(dir_reg, bus_wdata_in, bus_be_in);
                `DIO_OFS_REN: ren_next = merge(ren_reg, bus_wdata_in, bus_be_in);
                `DIO_OFS_DS: ds_next = merge(ds_reg, bus_wdata_in, bus_be_in);
                `DIO_OFS_SEL: sel_next = merge(sel_reg, bus_wdata_in, bus_be_in);
                `DIO_OFS_IE: ie_next = merge(ie_reg, bus_wdata_in, bus_be_in);
                `DIO_OFS_IFG: ifg_next = merge(ifg_reg, bus_wdata_in, bus_be_in);
                default: ;
            endcase
        end
        ifg_next = ((ifg_next & ~vec_clr) | hw_set) & PIN_MASK;
        // Request while any enabled flag stays pending and globally enabled
        irq1_next = |(ifg_next[7:0] & ie_next[7:0]) & global_irq_enable_in;
        irq2_next = |(ifg_next[15:8] & ie_next[15:8]) & global_irq_enable_in;
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Registered read; one cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_next = 16'h0000;
        rvalid_next = bus_rd_in;
        if (bus_rd_in) begin
            unique case (bus_addr_in)
                `DIO_OFS_IN: rdata_next = sync2_reg & PIN_MASK;
                `DIO_OFS_OUT: rdata_next = out_reg;
                `DIO_OFS_DIR: rdata_next = dir_reg;
                `DIO_OFS_REN: rdata_next = ren_reg;
                `DIO_OFS_DS: rdata_next = ds_reg;
                `DIO_OFS_SEL: rdata_next = sel_reg;
                `DIO_OFS_IES: rdata_next = ies_reg;
                `DIO_OFS_IE: rdata_next = ie_reg;
                `DIO_OFS_IFG: rdata_next = ifg_reg;
                `DIO_OFS_PORT1_VECTOR_REG: rdata_next = {8'h00, vec1};
                `DIO_OFS_PORT2_VECTOR_REG: rdata_next = {8'h00, vec2};
                default: rdata_next = 16'h0000;
            endcase
            // Byte read returns only that half in the low lane
            if (bus_be_in == 2'b10) begin
                rdata_next = {8'h00, rdata_next[15:8]};
            end else if (bus_be_in == 2'b01) begin
                rdata_next = {8'h00, rdata_next[7:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Pad control and peripheral input
    // ----------------------------------------------------------------
    always_comb begin
        pad_next.drive = ((sel_reg & periph_drive_in) | (~sel_reg & out_reg)) & PIN_MASK;
        pad_next.drive_en = dir_reg;
        // Pull only when an input; output bit picks its sense
        pad_next.pull_en = ren_reg & ~dir_reg;
        pad_next.pull_up = out_reg & ren_reg & ~dir_reg;
        pad_next.drive_full = ds_reg & dir_reg;
        // Latched copy of the pin: follows while selected, holds after
        periph_next = (sel_reg & sync2_reg) | (~sel_reg & periph_reg);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            out_reg <= `DIO_RST_WORD;
            dir_reg <= `DIO_RST_WORD;
            ren_reg <= `DIO_RST_WORD;
            ds_reg <= `DIO_RST_WORD;
            sel_reg <= `DIO_RST_WORD;
            ies_reg <= `DIO_RST_WORD;
            ie_reg <= `DIO_RST_WORD;
            ifg_reg <= `DIO_RST_WORD;
            periph_reg <= `DIO_RST_WORD;
            pad_reg <= '0;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            irq1_reg <= 1'b0;
            irq2_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            dir_reg <= dir_next;
            ren_reg <= ren_next;
            ds_reg <= ds_next;
            sel_reg <= sel_next;
            ies_reg <= ies_next;
            ie_reg <= ie_next;
            ifg_reg <= ifg_next;
            periph_reg <= periph_next;
            pad_reg <= pad_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            irq1_reg <= irq1_next;
            irq2_reg <= irq2_next;
        end
    end

    assign bus_rdata_out = rdata_reg;
    assign bus_rvalid_out = rvalid_reg;
    assign pad_out = pad_reg;
    assign periph_in_out = periph_reg;
    assign irq_p1_out = irq1_reg;
    assign irq_p2_out = irq2_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_p1_rise;
        !sync2_reg[0] ##1 sync2_reg[0];
    endsequence

    // Port 1 vector read in this cycle
    sequence s_p1_vec_read;
        bus_rd_in && bus_addr_in == `DIO_OFS_PORT1_VECTOR_REG && bus_be_in[0];
    endsequence

    a_rise_sets_flag: assert property (s_p1_rise ##0 (!ies_reg[0] && !sel_reg[0]) |=> ifg_reg[0])
        else $error("rising edge on pin 0 did not set its flag");
    a_sel_blocks_edge: assert property (sel_reg[1] && !ifg_reg[1]
        && !(bus_wr_in && bus_addr_in == `DIO_OFS_IFG) |=> !ifg_reg[1])
        else $error("selected pin set its flag");
    a_vec_value: assert property (s_p1_vec_read ##0 pend[0] |=> bus_rdata_out == 16'h0002)
        else $error("port 1 vector value wrong");
    a_vec_idle: assert property (pend[7:0] == 8'h00 && bus_rd_in
        && bus_addr_in == `DIO_OFS_PORT1_VECTOR_REG |=> bus_rdata_out == 16'h0000)
        else $error("idle vector not zero");
    a_vec_clears: assert property (acc1 && pend[0] && !hw_set[0] |=> !ifg_reg[0])
        else $error("vector access did not clear winner");
    a_vec_keeps_rest: assert property (acc1 && pend[0] && ifg_reg[2] |=> ifg_reg[2])
        else $error("vector access cleared a lower flag");
    a_irq_gate: assert property (irq_p1_out |-> $past(global_irq_enable_in))
        else $error("request without global enable");
    a_irq_follow: assert property ((|pend[7:0]) && global_irq_enable_in && !acc1
        && !(bus_wr_in && (bus_addr_in == `DIO_OFS_IE || bus_addr_in == `DIO_OFS_IFG)) |=> irq_p1_out)
        else $error("pending enabled flag gave no request");
    a_oe_dir: assert property (##1 pad_out.drive_en == $past(dir_reg))
        else $error("output enable does not follow direction");
    a_periph_hold: assert property ($fell(sel_reg[1]) |=> (periph_in_out[1] == $past(periph_in_out[1])) [*2])
        else $error("peripheral input not held");
    a_ies_flag: assert property (bus_wr_in && bus_addr_in == `DIO_OFS_IES && bus_be_in[0]
        && bus_wdata_in[7] && !ies_reg[7] && !sync2_reg[7] && !sel_reg[7] |=> ifg_reg[7])
        else $error("edge select change did not flag");
    a_in_readonly: assert property (bus_wr_in && bus_addr_in == `DIO_OFS_IN |=> $stable(out_reg))
        else $error("write to input register changed state");

    // ----------------------------------------------------------------
    // Pad, bus and port 2 checks
    // ----------------------------------------------------------------
    // Pull never fights the port driver
    a_pull_input: assert property ((pad_out.pull_en & pad_out.drive_en) == 16'h0000)
        else $error("pull enabled on an output");

    // Pull sense only counts with the pull on
    a_pull_sense: assert property ((pad_out.pull_up & ~pad_out.pull_en) == 16'h0000)
        else $error("pull sense without pull");

    // Full drive only where the pin drives
    a_full_drive: assert property ((pad_out.drive_full & ~pad_out.drive_en) == 16'h0000)
        else $error("full drive on an input");

    // Output bit reaches the pin one cycle later
    a_out_drive: assert property (dir_reg[0] && !sel_reg[0] |=> pad_out.drive[0] == $past(out_reg[0]))
        else $error("output pin does not follow output bit");

    // Read answers next cycle; data is zero between reads
    a_read_answer: assert property (bus_rd_in |=> bus_rvalid_out)
        else $error("read not answered");
    a_read_idle: assert property (!bus_rd_in |=> !bus_rvalid_out && bus_rdata_out == 16'h0000)
        else $error("read data outside a read");
    a_byte_upper: assert property (bus_rd_in && (bus_be_in == 2'b01 || bus_be_in == 2'b10)
        |=> bus_rdata_out[15:8] == 8'h00)
        else $error("byte read upper half not zero");

    // Input register reads the synchronised low pins
    a_in_low: assert property (bus_rd_in && bus_addr_in == `DIO_OFS_IN && bus_be_in == 2'b01
        |=> bus_rdata_out == ($past(sync2_reg) & PIN_MASK & 16'h00FF))
        else $error("input register value wrong");

    // Select write leaves direction alone
    a_sel_keeps_dir: assert property (bus_wr_in && bus_addr_in == `DIO_OFS_SEL |=> $stable(dir_reg))
        else $error("select write moved direction");

    // Software write of one sets the flag
    a_sw_set: assert property (bus_wr_in && bus_addr_in == `DIO_OFS_IFG && bus_be_in[0]
        && bus_wdata_in[0] |=> ifg_reg[0])
        else $error("software flag set lost");

    // No enable, no request
    a_no_enable: assert property (ie_reg[7:0] == 8'h00 && !bus_wr_in |=> !irq_p1_out)
        else $error("request with all enables off");

    // Port 2 has its own vector, clear and request
    a_p2_code: assert property (pend[15:8] == 8'h80 && bus_rd_in && bus_be_in[0]
        && bus_addr_in == `DIO_OFS_PORT2_VECTOR_REG |=> bus_rdata_out == 16'h0010)
        else $error("port 2 vector value wrong");
    a_p2_clears: assert property (acc2 && pend[15:8] == 8'h80 && !hw_set[15] |=> !ifg_reg[15])
        else $error("port 2 vector access did not clear");
    a_irq2_gate: assert property (irq_p2_out |-> $past(global_irq_enable_in))
        else $error("port 2 request without global enable");
endmodule

`default_nettype wire

// file: verif/dio_pin_model.sv
// Pin-side model: resolves each pin level from the pad controls and an external driver.
// Assumes the bench drives ext values at the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module dio_pin_model
    import dio_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Pad controls from the port
    input wire dio_pkg::dio_pad_s pad_in,
    // External driver on the board
    input wire logic [15:0] ext_val_in,
    input wire logic [15:0] ext_en_in,
    // Resolved pin levels
    output logic [15:0] pin_out
);
    // ----------------------------------------------------------------
    // Floating pins
    // ----------------------------------------------------------------
    // Toggles each cycle so an undriven pin never looks like a stable level
    logic [15:0] float_reg = 16'h5555;

    always @(posedge clk_in) begin
        float_reg <= ~float_reg;
    end

    // ----------------------------------------------------------------
    // Pin resolution
    // ----------------------------------------------------------------
    // Port driver first, then board driver, then resistor, else floating
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pad_in.drive_en[i]) begin
                pin_out[i] = pad_in.drive[i];
            end else if (ext_en_in[i]) begin
                pin_out[i] = ext_val_in[i];
            end else if (pad_in.pull_en[i]) begin
                pin_out[i] = pad_in.pull_up[i];
            end else begin
                pin_out[i] = float_reg[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/dio_port_tb.sv
// Self-checking bench for the digital I/O word port.
// Assumes dio_pin_model closes the pin loop; inputs change at the falling edge.
`include "dio_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module dio_port_tb;
    import dio_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [4:0] bus_addr_in = 5'h00;
    logic bus_rd_in = 1'b0;
    logic bus_wr_in = 1'b0;
    logic [1:0] bus_be_in = 2'b00;
    logic [15:0] bus_wdata_in = 16'h0000;
    logic [15:0] bus_rdata_out;
    logic bus_rvalid_out;
    logic [15:0] pin_level;
    dio_pad_s pad_out;
    logic [15:0] periph_in_out;
    logic global_irq_enable_in = 1'b0;
    logic irq_p1_out;
    logic irq_p2_out;
    logic [15:0] ext_val = 16'h0000;
    logic [15:0] ext_en = 16'hFFFF;
    logic [15:0] rd_data;
    logic [4:0] cfg_ofs [8] = '{`DIO_OFS_OUT, `DIO_OFS_DIR, `DIO_OFS_REN, `DIO_OFS_DS,
                                `DIO_OFS_SEL, `DIO_OFS_IES, `DIO_OFS_IE, `DIO_OFS_IFG};
    int err_count = 0;
    int checks_done = 0;

    // 250 MHz clock
    always #2 clk_in = ~clk_in;

    dio_port i_dut (.clk_in(clk_in), .srst_in(srst_in), .bus_addr_in(bus_addr_in), .bus_rd_in(bus_rd_in),
        .bus_wr_in(bus_wr_in), .bus_be_in(bus_be_in), .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
        .bus_rvalid_out(bus_rvalid_out), .pin_in(pin_level), .pad_out(pad_out), .periph_drive_in(16'h0000),
        .periph_in_out(periph_in_out), .global_irq_enable_in(global_irq_enable_in),
        .irq_p1_out(irq_p1_out), .irq_p2_out(irq_p2_out));

    dio_pin_model i_pins (.clk_in(clk_in), .pad_in(pad_out), .ext_val_in(ext_val), .ext_en_in(ext_en),
        .pin_out(pin_level));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Write strobe held for exactly one rising edge
    task automatic wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge clk_in);
        bus_addr_in = a;
        bus_be_in = be;
        bus_wdata_in = d;
        bus_wr_in = 1'b1;
        @(negedge clk_in);
        bus_wr_in = 1'b0;
    endtask

    // Read: data taken in the cycle where rvalid stands
    task automatic rc(input logic [4:0] a, input logic [1:0] be, input logic [15:0] exp, input string what);
        int n;
        @(negedge clk_in);
        bus_addr_in = a;
        bus_be_in = be;
        bus_rd_in = 1'b1;
        @(negedge clk_in);
        bus_rd_in = 1'b0;
        n = 0;
        while (bus_rvalid_out !== 1'b1 && n < 4) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 4) begin
            err_count++;
            $display("ERROR t=%0t read never answered", $time);
            wrap_up();
        end else begin
            rd_data = bus_rdata_out;
            check(rd_data, exp, what);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk_in);
        srst_in = 1'b0;
        foreach (cfg_ofs[i]) rc(cfg_ofs[i], 2'b11, 16'h0000, "reset value");
        check(pad_out.drive_full, 16'h0000, "reduced drive");
        rc(5'h10, 2'b11, 16'h0000, "unmapped read");
        // Word and byte halves
        wr(`DIO_OFS_OUT, 2'b11, 16'hA55A);
        wr(`DIO_OFS_OUT, 2'b01, 16'h003C);
        wr(`DIO_OFS_IN, 2'b11, 16'hFFFF);
        rc(`DIO_OFS_OUT, 2'b11, 16'hA53C, "word read");
        rc(`DIO_OFS_OUT, 2'b10, 16'h00A5, "high byte");
        // Output drive, board driver released half a cycle before the pad output enable rises
        wr(`DIO_OFS_DIR, 2'b01, 16'h00FF);
        ext_en = 16'hFF00;
        wr(`DIO_OFS_DS, 2'b01, 16'h000F);
        wr(`DIO_OFS_REN, 2'b01, 16'h00FF);
        repeat (6) @(negedge clk_in);
        rc(`DIO_OFS_IN, 2'b01, 16'h003C, "driven pins");
        check(pad_out.drive_full, 16'h000F, "full drive");
        check(pad_out.drive_en, 16'h00FF, "drive enable");
        check(pad_out.pull_en, 16'h0000, "no pull on output");
        // Pull resistors on inputs
        wr(`DIO_OFS_OUT, 2'b01, 16'h00F0);
        wr(`DIO_OFS_DIR, 2'b01, 16'h0000);
        repeat (6) @(negedge clk_in);
        rc(`DIO_OFS_IN, 2'b01, 16'h00F0, "pulled pins");
        check(pad_out.pull_up, 16'h00F0, "pull select");
        ext_val = 16'h0000;
        ext_en = 16'hFFFF;
        wr(`DIO_OFS_REN, 2'b01, 16'h0000);
        repeat (6) @(negedge clk_in);
        wr(`DIO_OFS_IFG, 2'b11, 16'h0000);
        // Rising edges, two flags masked
        global_irq_enable_in = 1'b1;
        wr(`DIO_OFS_IE, 2'b01, 16'h0020);
        ext_val = 16'h0025;
        repeat (6) @(negedge clk_in);
        rc(`DIO_OFS_IFG, 2'b01, 16'h0025, "edge flags");
        check(irq_p1_out, 1'b1, "irq raised");
        rc(`DIO_OFS_PORT1_VECTOR_REG, 2'b01, 16'h000C, "masked skipped");
        rc(`DIO_OFS_IFG, 2'b01, 16'h0005, "masked kept");
        check(irq_p1_out, 1'b0, "masked no irq");
        wr(`DIO_OFS_IE, 2'b01, 16'h0024);
        repeat (2) @(negedge clk_in);
        check(irq_p1_out, 1'b1, "irq again");
        rc(`DIO_OFS_PORT1_VECTOR_REG, 2'b01, 16'h0006, "priority");
        rc(`DIO_OFS_PORT1_VECTOR_REG, 2'b01, 16'h0000, "idle vector");
        // Software flag and global enable
        global_irq_enable_in = 1'b0;
        wr(`DIO_OFS_IE, 2'b01, 16'h0025);
        wr(`DIO_OFS_IFG, 2'b01, 16'h0005);
        repeat (2) @(negedge clk_in);
        check(irq_p1_out, 1'b0, "global off");
        global_irq_enable_in = 1'b1;
        repeat (2) @(negedge clk_in);
        check(irq_p1_out, 1'b1, "global on");
        rc(`DIO_OFS_PORT1_VECTOR_REG, 2'b01, 16'h0002, "pin zero code");
        rc(`DIO_OFS_PORT1_VECTOR_REG, 2'b01, 16'h0006, "next pending");
        // Edge-select change, then falling edges
        ext_val = 16'h0000;
        repeat (6) @(negedge clk_in);
        wr(`DIO_OFS_IFG, 2'b11, 16'h0000);
        wr(`DIO_OFS_IES, 2'b01, 16'h0080);
        rc(`DIO_OFS_IFG, 2'b01, 16'h0080, "select change");
        wr(`DIO_OFS_IFG, 2'b11, 16'h0000);
        ext_val = 16'h0080;
        repeat (6) @(negedge clk_in);
        rc(`DIO_OFS_IFG, 2'b01, 16'h0000, "rising ignored");
        ext_val = 16'h0000;
        repeat (6) @(negedge clk_in);
        rc(`DIO_OFS_IFG, 2'b01, 16'h0080, "falling flag");
        wr(`DIO_OFS_IFG, 2'b11, 16'h0000);
        // Peripheral function
        wr(`DIO_OFS_SEL, 2'b01, 16'h0002);
        wr(`DIO_OFS_IE, 2'b01, 16'h0002);
        wr(`DIO_OFS_IES, 2'b01, 16'h0000);
        ext_val = 16'h0002;
        repeat (6) @(negedge clk_in);
        rc(`DIO_OFS_IFG, 2'b01, 16'h0000, "selected no flag");
        rc(`DIO_OFS_DIR, 2'b11, 16'h0000, "dir untouched");
        check(periph_in_out & 16'h0002, 16'h0002, "periph follows");
        wr(`DIO_OFS_SEL, 2'b01, 16'h0000);
        ext_val = 16'h0000;
        repeat (6) @(negedge clk_in);
        check(periph_in_out & 16'h0002, 16'h0002, "periph holds");
        // Port 2 vector
        wr(`DIO_OFS_IE, 2'b10, 16'h8000);
        wr(`DIO_OFS_IFG, 2'b10, 16'h8000);
        repeat (2) @(negedge clk_in);
        check({irq_p2_out, irq_p1_out}, 2'b10, "port2 irq");
        rc(`DIO_OFS_PORT2_VECTOR_REG, 2'b01, 16'h0010, "pin seven code");
        rc(`DIO_OFS_IFG, 2'b10, 16'h0000, "port2 cleared");
        wrap_up();
    end
endmodule
`default_nettype wire
